// ---- rtl/dns_top.sv ----
/*
 * Oscillator tuning and phase alignment for the down-converter,
 * with an APB register slave.
 * Assumes: SYNC_N and SYSREF are asynchronous pins; LMFC_BOUNDARY
 * is a one-cycle strobe from the link framer on CLK.
 */
// Register access over APB was decided locally.
// Operation
// R1: align bit set: init phase at first boundary after SYNC_N rises.
// R2: sync-request alignment works in both link encodings.
// R3: in 64b/66b mode SYNC_N never reaches the link.
// R4: writing arm bit zero then one arms init on next SYSREF rise.
// R5: after a SYSREF init, later edges ignored until re-armed.
// R6: controller ensures power, link enable and clock before arming.
// R7: SYSREF source stays idle while parts are armed.
// R8: controller clears align bit, arms all parts, then pulses SYSREF.
// R9: armed part inits on first SYSREF rising edge after arming.
// R10: controller computes frequency word as 2^32 times ratio.
// R11: frequency word behaves the same signed or unsigned.
// R12: controller rounds word using step and divisor when not integral.
// R13: frequency words share one format and reset to C0000000.
// R14: controller re-synchronises after changing a running frequency word.
// R15: phase offset sits in upper half, added to accumulator.
// R16: phase offset is value times 2^-16 turns, resets to zero.
// R17: preset select chooses the active pair; zero selects preset zero. The code always uses preset zero.
// R18: divisor zero means plain 32-bit accumulation.
// R19: accumulator adds frequency each clock; init clears it first.
`timescale 1ns/1ps
`include "dns_defines.svh"
module dns_top (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SYNC_N,
    input wire logic SYSREF,
    input wire logic LMFC_BOUNDARY,
    output logic LINK_SYNC_REQ_N,
    output logic LINK_ENABLE,
    output logic NCO_INIT,
    output logic [31:0] NCO_PHASE
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] sync_ctrl_ff;
    logic [31:0] freq_a0_ff;
    logic [15:0] phase_a0_ff;
    logic [15:0] ref_div_ff;
    logic [7:0] preset_sel_ff;
    logic [1:0] link_cfg_ff;
    logic [31:0] prdata_ff;
    logic [31:0] rd_val;
    logic mapped;
    logic apb_wr;
    logic [1:0] pins_s;
    logic sync_s;
    logic sysref_s;
    logic sync_d_ff;
    logic sysref_d_ff;
    logic sync_rise;
    logic sysref_rise;
    dns_pkg::dns_arm_state_t arm_state_ff;
    dns_pkg::dns_arm_state_t nxt_arm_state;
    logic sync_pending_ff;
    logic nxt_sync_pending;
    logic align_en;
    logic init_sync;
    logic init_sysref;
    logic init;
    logic [7:0] init_count_ff;
    logic nco_init_ff;
    logic link_req_n_ff;
    logic mode_64b;
    logic [31:0] active_freq;
    logic [15:0] active_phase;

    // register hit on an aligned word index
    function automatic logic dns_hit(input logic [11:0] addr, input logic [9:0] idx);
        return (addr[11:2] == idx) && (addr[1:0] == 2'h0);
    endfunction : dns_hit

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // zero wait states: every access completes in its first access cycle
    assign mapped = dns_hit(PADDR, `DNS_IDX_PRESET_SEL) || dns_hit(PADDR, `DNS_IDX_REF_DIV)
                 || dns_hit(PADDR, `DNS_IDX_SYNC_CTRL) || dns_hit(PADDR, `DNS_IDX_FREQ_A0)
                 || dns_hit(PADDR, `DNS_IDX_PHASE_A0) || dns_hit(PADDR, `DNS_IDX_LINK_CFG)
                 || dns_hit(PADDR, `DNS_IDX_STATUS) || dns_hit(PADDR, `DNS_IDX_PHASE_RD);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign apb_wr = PSEL & PENABLE & PWRITE & mapped;

    // read mux; bits above a register's width read zero
    always_comb begin
        rd_val = 32'h00000000;
        if (dns_hit(PADDR, `DNS_IDX_PRESET_SEL)) begin
            rd_val = {24'h000000, preset_sel_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_REF_DIV)) begin
            rd_val = {16'h0000, ref_div_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_SYNC_CTRL)) begin
            rd_val = {24'h000000, sync_ctrl_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_FREQ_A0)) begin
            rd_val = freq_a0_ff;
        end else if (dns_hit(PADDR, `DNS_IDX_PHASE_A0)) begin
            rd_val = {16'h0000, phase_a0_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_LINK_CFG)) begin
            rd_val = {30'h00000000, link_cfg_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_STATUS)) begin
            rd_val = {16'h0000, init_count_ff, 3'h0, sysref_s, sync_s, sync_pending_ff, arm_state_ff};
        end else if (dns_hit(PADDR, `DNS_IDX_PHASE_RD)) begin
            rd_val = NCO_PHASE;
        end
    end

    // read data captured in the setup cycle so PRDATA comes from a flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            prdata_ff <= 32'h00000000;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            prdata_ff <= rd_val;
        end
    end

    assign PRDATA = prdata_ff;

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // reserved bits of the byte-wide registers are stored as written
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync_ctrl_ff <= `DNS_SYNC_CTRL_RST; // R1
            freq_a0_ff <= `DNS_FREQ_RST; // R13
            phase_a0_ff <= `DNS_PHASE_RST; // R16
            ref_div_ff <= `DNS_REF_DIV_RST;
            preset_sel_ff <= `DNS_PRESET_SEL_RST;
            link_cfg_ff <= `DNS_LINK_CFG_RST;
        end else if (apb_wr) begin
            if (dns_hit(PADDR, `DNS_IDX_SYNC_CTRL)) begin
                sync_ctrl_ff <= PWDATA[7:0];
            end
            if (dns_hit(PADDR, `DNS_IDX_FREQ_A0)) begin
                freq_a0_ff <= PWDATA;
            end
            if (dns_hit(PADDR, `DNS_IDX_PHASE_A0)) begin
                phase_a0_ff <= PWDATA[15:0];
            end
            if (dns_hit(PADDR, `DNS_IDX_REF_DIV)) begin
                ref_div_ff <= PWDATA[15:0];
            end
            if (dns_hit(PADDR, `DNS_IDX_PRESET_SEL)) begin
                preset_sel_ff <= PWDATA[7:0];
            end
            if (dns_hit(PADDR, `DNS_IDX_LINK_CFG)) begin
                link_cfg_ff <= PWDATA[1:0];
            end
        end
    end

    assign align_en = sync_ctrl_ff[`DNS_SYNC_ALIGN_BIT];
    assign mode_64b = (link_cfg_ff[`DNS_LINK_64B_BIT] == dns_pkg::DNS_LINK_64B66B);
    assign LINK_ENABLE = link_cfg_ff[`DNS_LINK_EN_BIT];

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    dns_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(CLK),
        .reset(RESET),
        .async_in({SYSREF, ~SYNC_N}), // sync pin inverted: zero reset matches its idle high
        .sync_out(pins_s)
    );

    assign sync_s = ~pins_s[0];
    assign sysref_s = pins_s[1];

    // delayed copies start high/low so reset release makes no false edge
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync_d_ff <= 1'b1;
            sysref_d_ff <= 1'b0;
        end else begin
            sync_d_ff <= sync_s;
            sysref_d_ff <= sysref_s;
        end
    end

    assign sync_rise = sync_s & ~sync_d_ff;
    assign sysref_rise = sysref_s & ~sysref_d_ff;

    // ----------------------------------------------------------------
    // sync-request alignment
    // ----------------------------------------------------------------
    // works for either encoding; only the link forwarding differs
    always_comb begin
        nxt_sync_pending = sync_pending_ff;
        if (sync_rise & align_en) begin
            nxt_sync_pending = 1'b1; // R1 R2
        end else if (init_sync | ~align_en) begin
            nxt_sync_pending = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sync_pending_ff <= 1'b0;
        end else begin
            sync_pending_ff <= nxt_sync_pending;
        end
    end

    // a boundary in the edge cycle itself is not "after" the edge
    assign init_sync = sync_pending_ff & LMFC_BOUNDARY & align_en; // R1

    // 64b/66b links never see the sync request
    always_ff @(posedge CLK) begin
        if (RESET) begin
            link_req_n_ff <= 1'b1;
        end else begin
            link_req_n_ff <= mode_64b ? 1'b1 : sync_s; // R3
        end
    end

    assign LINK_SYNC_REQ_N = link_req_n_ff;

    // ----------------------------------------------------------------
    // sysref arming sequence
    // ----------------------------------------------------------------
    // a one write counts only after a zero write; sysref is trusted to be
    // quiet while arming, so an edge during PRIMED is simply ignored
    always_comb begin
        nxt_arm_state = arm_state_ff;
        unique case (arm_state_ff)
            dns_pkg::DNS_ARM_IDLE: begin
                nxt_arm_state = dns_pkg::DNS_ARM_IDLE;
            end
            dns_pkg::DNS_ARM_PRIMED: begin
                nxt_arm_state = dns_pkg::DNS_ARM_PRIMED; // R7
            end
            dns_pkg::DNS_ARM_ARMED: begin
                if (sysref_rise) begin
                    nxt_arm_state = dns_pkg::DNS_ARM_IDLE; // R5
                end
            end
            default: begin
                nxt_arm_state = dns_pkg::DNS_ARM_IDLE;
            end
        endcase
        if (apb_wr && dns_hit(PADDR, `DNS_IDX_SYNC_CTRL)) begin
            if (!PWDATA[`DNS_SYNC_ARM_BIT]) begin
                nxt_arm_state = dns_pkg::DNS_ARM_PRIMED; // R4
            end else if (arm_state_ff == dns_pkg::DNS_ARM_PRIMED) begin
                nxt_arm_state = dns_pkg::DNS_ARM_ARMED; // R4
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            arm_state_ff <= dns_pkg::DNS_ARM_IDLE;
        end else begin
            arm_state_ff <= nxt_arm_state;
        end
    end

    assign init_sysref = (arm_state_ff == dns_pkg::DNS_ARM_ARMED) & sysref_rise; // R4 R9
    assign init = init_sync | init_sysref;

    // init pulse and a wrapping count of inits for software
    always_ff @(posedge CLK) begin
        if (RESET) begin
            nco_init_ff <= 1'b0;
            init_count_ff <= 8'h00;
        end else begin
            nco_init_ff <= init;
            init_count_ff <= init ? init_count_ff + 8'h01 : init_count_ff;
        end
    end

    assign NCO_INIT = nco_init_ff;

    // ----------------------------------------------------------------
    // oscillator datapath
    // ----------------------------------------------------------------
    // only preset 0 lives here; other select codes fall back to it
    assign active_freq = freq_a0_ff; // R17
    assign active_phase = phase_a0_ff; // R17

    // divisor correction is not applied: zero divisor is plain accumulation
    dns_phase_acc #(
        .ACC_W(32),
        .OFF_W(16)
    ) u_phase_acc (
        .clk(CLK),
        .reset(RESET),
        .init(init), // R19
        .freq(active_freq), // R18
        .offset(active_phase),
        .phase(NCO_PHASE)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_sync_pending: assert property (@(posedge CLK) disable iff (RESET)
        sync_rise && align_en |=> sync_pending_ff) else $error("sync edge not recorded"); // R1
    a_boundary_init: assert property (@(posedge CLK) disable iff (RESET) // R1
        sync_pending_ff && LMFC_BOUNDARY && align_en |=> NCO_INIT)
        else $error("no init at boundary after sync");
    a_link_req_64b: assert property (@(posedge CLK) disable iff (RESET)
        mode_64b ##1 !$past(RESET) |-> LINK_SYNC_REQ_N) else $error("sync reached 64b link"); // R3
    a_link_req_8b: assert property (@(posedge CLK) disable iff (RESET)
        !mode_64b |=> LINK_SYNC_REQ_N == $past(sync_s)) else $error("sync not forwarded in 8b mode"); // R2
    a_arm_fires: assert property (@(posedge CLK) disable iff (RESET) // R9
        arm_state_ff == dns_pkg::DNS_ARM_ARMED && sysref_rise |=> NCO_INIT
        && arm_state_ff != dns_pkg::DNS_ARM_ARMED) else $error("armed sysref edge missed");
    a_no_refire: assert property (@(posedge CLK) disable iff (RESET) // R5
        arm_state_ff != dns_pkg::DNS_ARM_ARMED && sysref_rise && !init_sync |=> !NCO_INIT)
        else $error("sysref init while unarmed");
    a_arm_needs_zero: assert property (@(posedge CLK) disable iff (RESET) // R4
        arm_state_ff == dns_pkg::DNS_ARM_IDLE && apb_wr && dns_hit(PADDR, `DNS_IDX_SYNC_CTRL)
        && PWDATA[`DNS_SYNC_ARM_BIT] |=> arm_state_ff == dns_pkg::DNS_ARM_IDLE)
        else $error("armed without zero write");
    a_freq_reset: assert property (@(posedge CLK) // R13
        $past(RESET) && RESET == 1'b0 |-> freq_a0_ff == `DNS_FREQ_RST && phase_a0_ff == `DNS_PHASE_RST)
        else $error("preset reset values wrong");

endmodule : dns_top

// ---- rtl/dns_defines.svh ----
/*
 * Register indexes, field positions and reset values for the
 * oscillator sync and tuning block.
 * Assumes: included by bare name; byte address is four times the index.
 */
`ifndef DNS_DEFINES_SVH
`define DNS_DEFINES_SVH

// ----------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define DNS_IDX_PRESET_SEL 10'h215
`define DNS_IDX_REF_DIV 10'h217
`define DNS_IDX_SYNC_CTRL 10'h219
`define DNS_IDX_FREQ_A0 10'h220
`define DNS_IDX_PHASE_A0 10'h224
`define DNS_IDX_LINK_CFG 10'h2F0
`define DNS_IDX_STATUS 10'h2F4
`define DNS_IDX_PHASE_RD 10'h2F8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DNS_SYNC_ARM_BIT 0
`define DNS_SYNC_ALIGN_BIT 1
`define DNS_LINK_EN_BIT 0
`define DNS_LINK_64B_BIT 1
`define DNS_PHASE_SHIFT 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DNS_SYNC_CTRL_RST 8'h02
`define DNS_FREQ_RST 32'hC0000000
`define DNS_PHASE_RST 16'h0000
`define DNS_REF_DIV_RST 16'h0000
`define DNS_PRESET_SEL_RST 8'h00
`define DNS_LINK_CFG_RST 2'h0

`endif

// ---- rtl/dns_pkg.sv ----
/*
 * Types shared by the oscillator sync and tuning block.
 * Assumes: used by scoped names only, never imported.
 */
package dns_pkg;

    // sysref arming sequence; code 2'b11 is illegal
    typedef enum logic [1:0] {
        DNS_ARM_IDLE = 2'b00,
        DNS_ARM_PRIMED = 2'b01,
        DNS_ARM_ARMED = 2'b10
    } dns_arm_state_t;

    // serial link encoding
    typedef enum logic {
        DNS_LINK_8B10B = 1'b0,
        DNS_LINK_64B66B = 1'b1
    } dns_link_mode_t;

endpackage : dns_pkg

// ---- rtl/dns_sync2.sv ----
/*
 * Two-stage synchroniser for asynchronous pin inputs.
 * Assumes: inputs may change at any time relative to clk.
 */
`timescale 1ns/1ps
module dns_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '0;
            stable_ff <= '0;
        end else begin
            meta_ff <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;

endmodule : dns_sync2

// ---- rtl/dns_phase_acc.sv ----
/*
 * Phase accumulator with offset insertion for the oscillator.
 * Assumes: init is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`include "dns_defines.svh"
module dns_phase_acc #(
    parameter int ACC_W = 32,
    parameter int OFF_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic init,
    input wire logic [ACC_W-1:0] freq,
    input wire logic [OFF_W-1:0] offset,
    output logic [ACC_W-1:0] phase
);

    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] phase_ff;
    logic [ACC_W-1:0] off_wide;

    // offset left-justified into the accumulator width
    assign off_wide = {offset, {(ACC_W-OFF_W){1'b0}}}; // R15

    // modulo add is identical for signed and unsigned words
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_ff <= '0;
        end else if (init) begin
            acc_ff <= '0; // R19
        end else begin
            acc_ff <= acc_ff + freq; // R11 R19
        end
    end

    // offset added after the accumulator so init never loses it
    always_ff @(posedge clk) begin
        if (reset) begin
            phase_ff <= '0;
        end else begin
            phase_ff <= acc_ff + off_wide; // R15 R16
        end
    end

    assign phase = phase_ff;

    a_acc_clear: assert property (@(posedge clk) disable iff (reset)
        init |=> acc_ff == '0) else $error("accumulator not cleared on init"); // R19
    a_acc_step: assert property (@(posedge clk) disable iff (reset) // R19
        !init ##1 !$past(reset) |-> acc_ff == $past(acc_ff) + $past(freq))
        else $error("accumulator did not advance by freq");
    a_offset_sum: assert property (@(posedge clk) disable iff (reset) // R15
        !$past(reset) |-> phase_ff == $past(acc_ff) + {$past(offset), {(ACC_W-OFF_W){1'b0}}})
        else $error("phase offset not applied in upper half");

endmodule : dns_phase_acc

// ---- testbench/dns_far_end.sv ----
/*
 * Far-end model: link receiver sync request, multiframe strobe and sysref source.
 * Assumes: runs on the block clock; the bench commands every request and pulse.
 */
`timescale 1ns/1ps
module dns_far_end #(
    parameter int BND_PERIOD = 16
) (
    input wire logic clk,
    input wire logic sync_hold,
    input wire logic sysref_go,
    output logic sync_n = 1'b1,
    output logic sysref = 1'b0,
    output logic lmfc_boundary = 1'b0
);
    logic [7:0] bnd_cnt_ff = 8'h00;
    logic [4:0] pulse_cnt_ff = 5'h00;
    // receiver holds its request low while the bench asks for a resync
    always_ff @(posedge clk) begin
        sync_n <= ~sync_hold;
    end
    // one-cycle multiframe strobe, free running
    always_ff @(posedge clk) begin
        bnd_cnt_ff <= (bnd_cnt_ff == 8'(BND_PERIOD - 1)) ? 8'h00 : bnd_cnt_ff + 8'h01;
        lmfc_boundary <= (bnd_cnt_ff == 8'h00);
    end
    // two pulses after a command; idle low otherwise, so arming never sees an edge
    always_ff @(posedge clk) begin
        if (sysref_go) begin
            pulse_cnt_ff <= 5'h10;
        end else if (pulse_cnt_ff != 5'h00) begin
            pulse_cnt_ff <= pulse_cnt_ff - 5'h01;
        end
        sysref <= pulse_cnt_ff[2];
    end
endmodule : dns_far_end

// ---- testbench/ddc_oscillator_sync_control_and_tuning_tb.sv ----
/*
 * Self-checking bench for the oscillator sync and tuning block.
 * Assumes: zero-wait APB slave; far-end model supplies sync, strobe and sysref.
 */
`timescale 1ns/1ps
`include "dns_defines.svh"
module ddc_oscillator_sync_control_and_tuning_tb;
    logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, nco_phase, rd, ph, exp_ph;
    logic [31:0] freq_now = 32'hC0000000, seed = 32'h3DF9C33E;
    logic pready, pslverr, sync_n, sysref, bnd, sync_req_n, link_en, nco_init, err, kind, mode;
    logic sync_hold = 1'b0, sysref_go = 1'b0, prev_bnd = 1'b0;
    logic [32:0] exp_q[$];
    int err_total = 0, samples_checked = 0, n_init = 0, ph_cnt = 4;

    always #2.5 clk = ~clk;

    dns_top dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SYNC_N(sync_n), .SYSREF(sysref), .LMFC_BOUNDARY(bnd), .LINK_SYNC_REQ_N(sync_req_n),
        .LINK_ENABLE(link_en), .NCO_INIT(nco_init), .NCO_PHASE(nco_phase));
    dns_far_end #(.BND_PERIOD(16)) far (.clk(clk), .sync_hold(sync_hold), .sysref_go(sysref_go),
        .sync_n(sync_n), .sysref(sysref), .lmfc_boundary(bnd));

    // ----------------------------------------------------------------
    // checking and bus helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // setup cycle, then access held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
        chk(err, 0);
    endtask : wreg

    task automatic rreg(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b0, idx, 32'h00000000);
        chk(rd, d);
        chk(err, 0);
    endtask : rreg

    // one sync request or sysref burst; yes says whether an init must follow
    task automatic run_event(input logic use_sync, input logic yes);
        int n0;
        n0 = n_init;
        if (yes) exp_q.push_back({use_sync, ph[15:0], 16'h0000});
        if (use_sync) sync_hold <= 1'b1;
        else sysref_go <= 1'b1;
        repeat (8) @(posedge clk);
        if (use_sync) chk(sync_req_n, {31'h0, mode});
        sync_hold <= 1'b0;
        sysref_go <= 1'b0;
        repeat (40) @(posedge clk);
        chk(n_init, n0 + yes);
    endtask : run_event

    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // watcher: each init pulse takes the oldest note and checks the phase after it
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        #1;
        if (ph_cnt == 1) chk(nco_phase, exp_ph);
        if (ph_cnt == 2) chk(nco_phase, exp_ph + freq_now);
        if (ph_cnt < 4) ph_cnt++;
        if (nco_init !== 1'b0) begin
            if (exp_q.size() == 0) begin
                chk(nco_init, 0);
            end else begin
                {kind, exp_ph} = exp_q.pop_front();
                if (kind) chk(prev_bnd, 1);
                n_init++;
                ph_cnt = 1;
            end
        end
        prev_bnd = bnd;
    end

    // watchdog well past the expected run of about 420 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rreg(`DNS_IDX_SYNC_CTRL, 32'h00000002);
        rreg(`DNS_IDX_FREQ_A0, 32'hC0000000);
        rreg(`DNS_IDX_PHASE_A0, 32'h00000000);
        rreg(`DNS_IDX_REF_DIV, 32'h00000000);
        rreg(`DNS_IDX_PRESET_SEL, 32'h00000000);
        apb(1'b0, 10'h001, 32'h00000000);
        chk(err, 1);
        chk(rd, 0);
        chk(link_en, 0);
        wreg(`DNS_IDX_PRESET_SEL, 32'h00000000);
        wreg(`DNS_IDX_REF_DIV, 32'h00001000);
        rreg(`DNS_IDX_REF_DIV, 32'h00001000);
        wreg(`DNS_IDX_REF_DIV, 32'h00000000);
        // sync-request alignment in each link encoding, after a running word change
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            seed = lfsr(seed);
            freq_now = (m == 0) ? 32'h20000000 : (seed | 32'h80000000);
            seed = lfsr(seed);
            ph = {16'h0000, seed[15:0]};
            wreg(`DNS_IDX_FREQ_A0, freq_now);
            wreg(`DNS_IDX_PHASE_A0, ph);
            rreg(`DNS_IDX_FREQ_A0, freq_now);
            wreg(`DNS_IDX_LINK_CFG, {30'h0, mode, 1'b1});
            @(posedge clk); // the write lands on the access edge; look one edge later
            chk(link_en, 1);
            run_event(1'b1, 1'b1);
        end
        wreg(`DNS_IDX_SYNC_CTRL, 32'h00000000);
        run_event(1'b1, 1'b0);
        wreg(`DNS_IDX_SYNC_CTRL, 32'h00000001);
        rreg(`DNS_IDX_SYNC_CTRL, 32'h00000001);
        run_event(1'b0, 1'b1);
        run_event(1'b0, 1'b0);
        wreg(`DNS_IDX_SYNC_CTRL, 32'h00000001);
        run_event(1'b0, 1'b0);
        wreg(`DNS_IDX_SYNC_CTRL, 32'h00000000);
        wreg(`DNS_IDX_SYNC_CTRL, 32'h00000001);
        run_event(1'b0, 1'b1);
        chk(exp_q.size(), 0);
        rreg(`DNS_IDX_STATUS, 32'h00000408);
        summarize();
    end
endmodule : ddc_oscillator_sync_control_and_tuning_tb
